/* logic/pph_regs.sv */
// host-visible register bank of a single-port power-sourcing manager
`timescale 1ns/1ps
`include "pph_defs.svh"
module pph_regs
  import pph_pkg::*;
#(
  parameter logic [2:0] DIG_REV = 3'h5, // arbitrary value
  parameter logic [2:0] ANA_REV = 3'h6 // arbitrary value
)
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic backfeed_evt,
  input wire logic [1:0] signature_result,
  input wire logic class_done,
  input wire logic class_ovl,
  input wire logic class_first_4,
  input wire logic class_second_4,
  input wire logic port_powered,
  input wire logic startup_fail_evt,
  input wire logic startup_begin,
  input wire logic bus_wd_evt,
  input wire logic disable_pin,
  input wire logic led_auto_on,
  output logic port_cycle,
  output logic soft_reset,
  output logic port_enable,
  output logic restart_detect,
  output logic led_o,
  output logic led_oe
);
  logic back_feed_flag_q, back_feed_flag_d;
  pph_class_t class_q, class_d;
  logic power_on_flag_q, power_on_flag_d;
  logic startup_failed_q, startup_failed_d;
  logic [3:0] scratch_q, scratch_d;
  logic [2:0] cause_q, cause_d;
  logic [1:0] led_q, led_d;
  logic [1:0] portctl_q, portctl_d;
  logic [7:0] rdata_q, rdata_d;
  logic cycle_q, cycle_d;
  logic srst_q, srst_d;
  logic pen_q, pen_d;
  logic restart_q, restart_d;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  // classification outcome from both events
  function automatic pph_class_t class_code(input logic ovl,
    input logic first4, input logic second4);
    if (ovl)
      class_code = PPH_CLS_OVL;
    else if (first4 != second4)
      class_code = PPH_CLS_DIFF;
    else if (first4)
      class_code = PPH_CLS_4;
    else
      class_code = PPH_CLS_0123;
  endfunction : class_code

  logic wr_event, wr_status, wr_scratch, wr_sreset;
  logic wr_cause, wr_led, wr_portctl;

  always_comb
  begin
    wr_event = reg_wr && hit(reg_addr, `PPH_ADDR_EVENT);
    wr_status = reg_wr && hit(reg_addr, `PPH_ADDR_STATUS);
    wr_scratch = reg_wr && hit(reg_addr, `PPH_ADDR_SCRATCH);
    wr_sreset = reg_wr && hit(reg_addr, `PPH_ADDR_SRESET);
    wr_cause = reg_wr && hit(reg_addr, `PPH_ADDR_CAUSE);
    wr_led = reg_wr && hit(reg_addr, `PPH_ADDR_LED);
    wr_portctl = reg_wr && hit(reg_addr, `PPH_ADDR_PORTCTL);
  end

  // port state and host-written registers
  always_comb
  begin
    back_feed_flag_d = back_feed_flag_q;
    class_d = class_q;
    power_on_flag_d = port_powered;
    startup_failed_d = startup_failed_q;
    scratch_d = scratch_q;
    cause_d = cause_q;
    led_d = led_q;
    portctl_d = portctl_q;
    cycle_d = 1'b0;
    srst_d = 1'b0;
    restart_d = 1'b0;
    if (wr_event)
      back_feed_flag_d = reg_wdata[`PPH_BIT_BACKFEED];
    if (backfeed_evt)
      back_feed_flag_d = 1'b1;
    if (class_done)
      class_d = class_code(class_ovl, class_first_4, class_second_4);
    if (startup_begin)
      startup_failed_d = 1'b0;
    if (startup_fail_evt)
      startup_failed_d = 1'b1;
    // only a written 0 acts; a 1 is ignored since the host never sends it
    if (wr_status && !reg_wdata[`PPH_BIT_PWR_ON])
      cycle_d = 1'b1;
    if (wr_scratch)
      scratch_d = reg_wdata[3:0];
    if (wr_led)
      led_d = reg_wdata[1:0];
    if (wr_portctl)
    begin
      portctl_d = reg_wdata[1:0];
      // only the 1 to 0 move of select restarts detection
      if (portctl_q[`PPH_BIT_OVR_SEL] && !reg_wdata[`PPH_BIT_OVR_SEL])
        restart_d = 1'b1;
    end
    if (wr_sreset && reg_wdata == `PPH_RESET_KEY)
      srst_d = 1'b1;
    if (wr_cause)
      cause_d = reg_wdata[2:0];
    if (bus_wd_evt)
      cause_d[`PPH_BIT_CAUSE_WD] = 1'b1;
    // soft reset returns device state to defaults; the cause survives
    if (srst_q)
    begin
      back_feed_flag_d = backfeed_evt;
      class_d = PPH_CLS_RESET;
      // a failure seen in the reset cycle still wins over the default
      startup_failed_d = startup_fail_evt;
      scratch_d = `PPH_RST_SCRATCH;
      led_d = `PPH_RST_LED;
      portctl_d = `PPH_RST_PORTCTL;
      cycle_d = 1'b0;
      restart_d = 1'b0;
      cause_d[`PPH_BIT_CAUSE_SW] = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      back_feed_flag_q <= 1'b0;
      class_q <= PPH_CLS_RESET;
      power_on_flag_q <= 1'b0;
      startup_failed_q <= 1'b0;
      scratch_q <= `PPH_RST_SCRATCH;
      cause_q <= `PPH_RST_CAUSE;
      led_q <= `PPH_RST_LED;
      portctl_q <= `PPH_RST_PORTCTL;
      cycle_q <= 1'b0;
      srst_q <= 1'b0;
      restart_q <= 1'b0;
    end
    else
    begin
      back_feed_flag_q <= back_feed_flag_d;
      class_q <= class_d;
      power_on_flag_q <= power_on_flag_d;
      startup_failed_q <= startup_failed_d;
      scratch_q <= scratch_d;
      cause_q <= cause_d;
      led_q <= led_d;
      portctl_q <= portctl_d;
      cycle_q <= cycle_d;
      srst_q <= srst_d;
      restart_q <= restart_d;
    end
  end

  // port enable: pin or host, dropped for one cycle on a push-button cycle
  always_comb
  begin
    if (portctl_q[`PPH_BIT_OVR_SEL])
      pen_d = portctl_q[`PPH_BIT_OVR_VAL];
    else
      pen_d = ~disable_pin;
    if (cycle_q || srst_q)
      pen_d = 1'b0;
  end

  // read data, one cycle after the strobe; unmapped reads give zero
  always_comb
  begin
    rdata_d = rdata_q;
    if (reg_rd)
    begin
      rdata_d = 8'h00;
      unique case (1'b1)
        hit(reg_addr, `PPH_ADDR_EVENT):
          rdata_d[`PPH_BIT_BACKFEED] = back_feed_flag_q;
        hit(reg_addr, `PPH_ADDR_STATUS):
          rdata_d = {1'b0, startup_failed_q, power_on_flag_q, class_q,
            signature_result};
        hit(reg_addr, `PPH_ADDR_SCRATCH):
          rdata_d = {4'h0, scratch_q};
        hit(reg_addr, `PPH_ADDR_CAUSE):
          rdata_d = {5'h00, cause_q};
        hit(reg_addr, `PPH_ADDR_VERSION):
          rdata_d = {2'h0, ANA_REV, DIG_REV};
        hit(reg_addr, `PPH_ADDR_LED):
          rdata_d = {6'h00, led_q};
        hit(reg_addr, `PPH_ADDR_PORTCTL):
          rdata_d = {6'h00, portctl_q};
        default:
          rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata_q <= 8'h00;
      pen_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      pen_q <= pen_d;
    end
  end

  pph_led_drive u_led (
    .mclk(mclk),
    .arst_n(arst_n),
    .ovr_sel(led_q[0]),
    .ovr_val(led_q[1]),
    .auto_on(led_auto_on),
    .led_o(led_o),
    .led_oe(led_oe)
  );

  assign reg_rdata = rdata_q;
  assign port_cycle = cycle_q;
  assign soft_reset = srst_q;
  assign port_enable = pen_q;
  assign restart_detect = restart_q;

  sequence key_write_s;
    wr_sreset && reg_wdata == `PPH_RESET_KEY;
  endsequence

  sequence soft_reset_s;
    soft_reset ##1 (scratch_q == `PPH_RST_SCRATCH
      && cause_q[`PPH_BIT_CAUSE_SW]);
  endsequence

  backfeed_set_a: assert property (@(posedge mclk) disable iff (!arst_n)
    backfeed_evt |=> back_feed_flag_q)
    else $error("back-feed flag not set");

  backfeed_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (back_feed_flag_q && !wr_event && !srst_q) |=> back_feed_flag_q)
    else $error("back-feed flag dropped without clear");

  class_diff_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (class_done && !class_ovl && class_first_4 != class_second_4
      && !srst_q) |=> class_q == PPH_CLS_DIFF)
    else $error("class mismatch not reported");

  class_ovl_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (class_done && class_ovl && !srst_q) |=> class_q == PPH_CLS_OVL)
    else $error("class overcurrent not reported");

  power_flag_a: assert property (@(posedge mclk) disable iff (!arst_n)
    port_powered |=> power_on_flag_q)
    else $error("power-on flag not following port");

  push_cycle_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (wr_status && !reg_wdata[`PPH_BIT_PWR_ON] && !srst_q)
      |=> port_cycle ##1 !port_enable)
    else $error("port not cycled on power flag clear");

  fail_flag_a: assert property (@(posedge mclk) disable iff (!arst_n)
    startup_fail_evt |=> startup_failed_q)
    else $error("start-up failure not flagged");

  scratch_rw_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (wr_scratch && !srst_q) |=> scratch_q == $past(reg_wdata[3:0]))
    else $error("scratch bits not written");

  soft_reset_a: assert property (@(posedge mclk) disable iff (!arst_n)
    key_write_s |=> soft_reset_s)
    else $error("key write did not reset the device");

  wd_cause_a: assert property (@(posedge mclk) disable iff (!arst_n)
    bus_wd_evt |=> cause_q[`PPH_BIT_CAUSE_WD])
    else $error("watchdog cause not set");

  version_rd_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (reg_rd && hit(reg_addr, `PPH_ADDR_VERSION))
      |=> reg_rdata == {2'h0, ANA_REV, DIG_REV})
    else $error("version read wrong");

  host_enable_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (portctl_q[`PPH_BIT_OVR_SEL] && !cycle_q && !srst_q)
      |=> port_enable == $past(portctl_q[`PPH_BIT_OVR_VAL]))
    else $error("port enable not under host control");

  pin_enable_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (!portctl_q[`PPH_BIT_OVR_SEL] && !cycle_q && !srst_q)
      |=> port_enable == !$past(disable_pin))
    else $error("port enable not following pin");

  restart_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (wr_portctl && portctl_q[`PPH_BIT_OVR_SEL]
      && !reg_wdata[`PPH_BIT_OVR_SEL] && !srst_q) |=> restart_detect)
    else $error("detection not restarted");

  ro_ignore_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (wr_status && !class_done && !srst_q) |=> $stable(class_q))
    else $error("read-only class field changed by write");

  fail_clear_a: assert property (@(posedge mclk)
    disable iff (!arst_n)
    (startup_begin && !startup_fail_evt) |=> !startup_failed_q)
    else $error("start-up failure not cleared on new start");

  cause_hold_a: assert property (@(posedge mclk)
    disable iff (!arst_n)
    (cause_q[`PPH_BIT_CAUSE_POR] && !wr_cause)
      |=> cause_q[`PPH_BIT_CAUSE_POR])
    else $error("power-up cause dropped without clear");

  restart_pulse_a: assert property (@(posedge mclk)
    disable iff (!arst_n)
    restart_detect |=> !restart_detect)
    else $error("detection restart longer than one cycle");
endmodule : pph_regs

/* logic/pph_defs.svh */
// register offsets, field positions, reset values and keys of the port bank
`ifndef PPH_DEFS_SVH
`define PPH_DEFS_SVH
`define PPH_ADDR_EVENT 8'h04
`define PPH_ADDR_STATUS 8'h0b
`define PPH_ADDR_SCRATCH 8'h0d
`define PPH_ADDR_SRESET 8'h0e
`define PPH_ADDR_CAUSE 8'h0f
`define PPH_ADDR_VERSION 8'h10
`define PPH_ADDR_LED 8'hb5
`define PPH_ADDR_PORTCTL 8'hd9
`define PPH_BIT_BACKFEED 7
`define PPH_BIT_PWR_ON 5
`define PPH_BIT_STARTUP_FAILED 6
`define PPH_BIT_CAUSE_POR 0
`define PPH_BIT_CAUSE_SW 1
`define PPH_BIT_CAUSE_WD 2
`define PPH_BIT_OVR_SEL 0
`define PPH_BIT_OVR_VAL 1
`define PPH_RST_SCRATCH 4'h0
`define PPH_RST_CAUSE 3'h1
`define PPH_RST_LED 2'h2
`define PPH_RST_PORTCTL 2'h0
`define PPH_RESET_KEY 8'hab
`endif

/* logic/pph_pkg.sv */
// types shared by the port register bank
package pph_pkg;
  typedef enum logic [2:0] {
    PPH_CLS_RESET = 3'h0,
    PPH_CLS_OVL = 3'h1,
    PPH_CLS_DIFF = 3'h2,
    PPH_CLS_0123 = 3'h3,
    PPH_CLS_4 = 3'h4
  } pph_class_t;
endpackage : pph_pkg

/* logic/pph_led_drive.sv */
// open-drain indicator driver with host override
`timescale 1ns/1ps
`include "pph_defs.svh"
module pph_led_drive
  import pph_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ovr_sel,
  input wire logic ovr_val,
  input wire logic auto_on,
  output logic led_o,
  output logic led_oe
);
  logic led_on;
  logic oe_q;
  logic oe_d;
  logic out_q;

  // host value is active low: 0 turns the indicator on
  always_comb
  begin
    led_on = ovr_sel ? ~ovr_val : auto_on;
    oe_d = led_on;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      oe_q <= 1'b0;
      out_q <= 1'b0;
    end
    else
    begin
      oe_q <= oe_d;
      out_q <= 1'b0;
    end
  end

  assign led_oe = oe_q;
  assign led_o = out_q;

  led_follow_a: assert property (@(posedge mclk) disable iff (!arst_n)
    ovr_sel |=> (led_oe == ~$past(ovr_val)))
    else $error("indicator does not follow host value");
endmodule : pph_led_drive

/* tb/pph_port_model.sv */
// far-side port model: powers the port some cycles after enable
`timescale 1ns/1ps
module pph_port_model #(
  parameter int DLY = 6
)
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic port_enable,
  input wire logic restart_detect,
  output logic port_powered,
  output logic led_auto_on
);
  int cnt_q;
  // a restart drops power, as a fresh detection cycle would
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_q <= 0;
    else if (!port_enable || restart_detect)
      cnt_q <= 0;
    else if (cnt_q < DLY)
      cnt_q <= cnt_q + 1;
  end
  assign port_powered = (cnt_q == DLY);
  assign led_auto_on = port_powered;
endmodule : pph_port_model

/* tb/pph_port_host_registers_tb_top.sv */
// self-checking bench for the port host register bank
`timescale 1ns/1ps
`include "pph_defs.svh"
module pph_port_host_registers_tb_top;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdat = 8'h00;
  logic [7:0] rdat;
  logic [1:0] sig = 2'h0;
  logic wr = 1'b0, rd = 1'b0, bf = 1'b0, cdone = 1'b0, covl = 1'b0;
  logic c1 = 1'b0, c2 = 1'b0, sfail = 1'b0, sbeg = 1'b0, wd = 1'b0;
  logic dpin = 1'b0;
  logic pwr, ledon, pcyc, srst, pen, rdet, led_o, led_oe;
  logic [2:0] cls [4] = '{3'b100, 3'b010, 3'b000, 3'b011};
  int err_count = 0;
  int n_compared = 0;
  int n_cyc = 0;
  int n_srst = 0;
  int n_rdet = 0;
  always #2.5 mclk = ~mclk;
  pph_regs dut_u (
    .mclk(mclk), .arst_n(arst_n), .reg_addr(addr), .reg_wr(wr),
    .reg_wdata(wdat), .reg_rd(rd), .reg_rdata(rdat),
    .backfeed_evt(bf), .signature_result(sig), .class_done(cdone),
    .class_ovl(covl), .class_first_4(c1), .class_second_4(c2),
    .port_powered(pwr), .startup_fail_evt(sfail),
    .startup_begin(sbeg), .bus_wd_evt(wd), .disable_pin(dpin),
    .led_auto_on(ledon), .port_cycle(pcyc), .soft_reset(srst),
    .port_enable(pen), .restart_detect(rdet), .led_o(led_o),
    .led_oe(led_oe));
  pph_port_model model_u (
    .mclk(mclk), .arst_n(arst_n), .port_enable(pen),
    .restart_detect(rdet), .port_powered(pwr), .led_auto_on(ledon));
  always @(posedge mclk)
  begin
    n_cyc += (pcyc === 1'b1);
    n_srst += (srst === 1'b1);
    n_rdet += (rdet === 1'b1);
  end
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    tick(1);
    #1;
    chk(rdat, exp);
  endtask : rd_chk
  // bounded wait on the model's power level; looks 1 ns after the edge
  // so the model's count has settled
  task automatic wait_pwr(input logic v);
    #1;
    for (int i = 0; i < 100 && pwr !== v; i++)
    begin
      @(posedge mclk);
      #1;
    end
    chk({7'h0, pwr}, {7'h0, v});
    if (pwr !== v)
      print_verdict();
  endtask : wait_pwr
  initial
  begin
    tick(10);
    arst_n <= 1'b1;
    rd_chk(`PPH_ADDR_SCRATCH, 8'h00);
    rd_chk(`PPH_ADDR_CAUSE, 8'h01);
    rd_chk(`PPH_ADDR_VERSION, 8'h35);
    rd_chk(`PPH_ADDR_LED, 8'h02);
    rd_chk(`PPH_ADDR_PORTCTL, 8'h00);
    rd_chk(`PPH_ADDR_SRESET, 8'h00);
    rd_chk(8'h20, 8'h00);
    wr_reg(`PPH_ADDR_VERSION, 8'hff);
    rd_chk(`PPH_ADDR_VERSION, 8'h35);
    $display("test reset done");
    @(posedge mclk);
    sig <= 2'h2;
    wait_pwr(1'b1);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge mclk);
      {covl, c1, c2} <= cls[k];
      cdone <= 1'b1;
      @(posedge mclk);
      cdone <= 1'b0;
      rd_chk(`PPH_ADDR_STATUS, {3'b001, 3'(k + 1), 2'h2});
    end
    @(posedge mclk);
    sfail <= 1'b1;
    @(posedge mclk);
    sfail <= 1'b0;
    rd_chk(`PPH_ADDR_STATUS, 8'h72);
    wr_reg(`PPH_ADDR_STATUS, 8'h5f);
    tick(3);
    chk(8'(n_cyc), 8'h01);
    wait_pwr(1'b1);
    rd_chk(`PPH_ADDR_STATUS, 8'h72);
    @(posedge mclk);
    sbeg <= 1'b1;
    @(posedge mclk);
    sbeg <= 1'b0;
    rd_chk(`PPH_ADDR_STATUS, 8'h32);
    $display("test status done");
    @(posedge mclk);
    bf <= 1'b1;
    @(posedge mclk);
    bf <= 1'b0;
    rd_chk(`PPH_ADDR_EVENT, 8'h80);
    rd_chk(`PPH_ADDR_EVENT, 8'h80);
    wr_reg(`PPH_ADDR_EVENT, 8'h00);
    rd_chk(`PPH_ADDR_EVENT, 8'h00);
    $display("test backfeed done");
    wr_reg(`PPH_ADDR_PORTCTL, 8'h01);
    tick(3);
    chk({7'h0, pen}, 8'h00);
    wr_reg(`PPH_ADDR_PORTCTL, 8'h03);
    @(posedge mclk);
    dpin <= 1'b1;
    tick(3);
    chk({7'h0, pen}, 8'h01);
    rd_chk(`PPH_ADDR_PORTCTL, 8'h03);
    wr_reg(`PPH_ADDR_PORTCTL, 8'h00);
    tick(3);
    chk({7'h0, pen}, 8'h00);
    chk(8'(n_rdet), 8'h01);
    @(posedge mclk);
    dpin <= 1'b0;
    wait_pwr(1'b1);
    $display("test portctl done");
    tick(2);
    chk({6'h0, led_o, led_oe}, 8'h01);
    wr_reg(`PPH_ADDR_LED, 8'h03);
    tick(2);
    chk({6'h0, led_o, led_oe}, 8'h00);
    wr_reg(`PPH_ADDR_LED, 8'h01);
    tick(2);
    chk({6'h0, led_o, led_oe}, 8'h01);
    wr_reg(`PPH_ADDR_LED, 8'h02);
    @(posedge mclk);
    dpin <= 1'b1;
    wait_pwr(1'b0);
    tick(2);
    chk({6'h0, led_o, led_oe}, 8'h00);
    @(posedge mclk);
    dpin <= 1'b0;
    $display("test led done");
    wr_reg(`PPH_ADDR_SCRATCH, 8'hfa);
    rd_chk(`PPH_ADDR_SCRATCH, 8'h0a);
    @(posedge mclk);
    wd <= 1'b1;
    @(posedge mclk);
    wd <= 1'b0;
    tick(2);
    chk({7'h0, pen}, 8'h01);
    rd_chk(`PPH_ADDR_CAUSE, 8'h05);
    wr_reg(`PPH_ADDR_SRESET, 8'haa);
    tick(2);
    chk(8'(n_srst), 8'h00);
    wr_reg(`PPH_ADDR_SRESET, 8'hab);
    tick(3);
    chk(8'(n_srst), 8'h01);
    rd_chk(`PPH_ADDR_CAUSE, 8'h07);
    rd_chk(`PPH_ADDR_SCRATCH, 8'h00);
    wr_reg(`PPH_ADDR_CAUSE, 8'h00);
    rd_chk(`PPH_ADDR_CAUSE, 8'h00);
    $display("test reset cause done");
    print_verdict();
  end
endmodule : pph_port_host_registers_tb_top
